// ### design/pocic_pkg.sv
// Purpose: shared constants and types of the pin option, clock and irq block
// Assumes: 8-bit register port, one 20 MHz clock
// Notes: option bit positions follow the option register layout
package pocic_pkg;
  // register offsets
  localparam logic [7:0] OFS_PA_DIR = 8'h04;
  localparam logic [7:0] OFS_PB_DIR = 8'h05;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0A;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0B;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_PA_PDI = 8'h10;
  localparam logic [7:0] OFS_PB_PDI = 8'h11;
  localparam logic [7:0] OFS_OPTION = 8'h12;
  // option_config_one fields
  localparam int OPT_SHORT_DLY = 7;
  localparam int OPT_THREE_PIN = 6;
  localparam int OPT_RC = 5;
  localparam int OPT_PULLDOWN = 3;
  localparam int OPT_KBD_IRQ = 2;
  localparam int OPT_LEVEL_IRQ = 1;
  // status and mask fields
  localparam int ST_IRQ_EDGE = 0;
  localparam int ST_WDOG = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int NUM_EVT = 3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [NUM_EVT-1:0] RST_EVT = 3'h0;
  // startup delays in internal operating clock cycles
  localparam int LONG_DLY_CYC = 4064;
  localparam int SHORT_DLY_CYC = 16;
  localparam int DLY_W = 12;
  // clock: oscillator divided by two
  localparam int OSC_DIV = 2;

  typedef enum logic [1:0] {
    OSC_XTAL = 2'h0,
    OSC_RC2 = 2'h1,
    OSC_RC3 = 2'h3
  } pocic_osc_t;

  // gray codes along reset -> delay -> run
  typedef enum logic [1:0] {
    PS_RESET = 2'h0,
    PS_DELAY = 2'h1,
    PS_RUN = 2'h3
  } pocic_pwr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pocic_bus_t;
endpackage : pocic_pkg

// ### design/pocic_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pocic_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3, next_dout;

  // s1 feeds only s2
  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
      dout <= IDLE;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : pocic_sync
`default_nettype wire

// ### design/pocic_top.sv
// Purpose: option-driven clock, oscillator pin, reset pin and irq logic
// Assumes: clk is the oscillator input; option bits arrive as straps
// Notes: option register is read-only, caught once after reset release
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - the operating clock is the oscillator rate divided by two.
// - rc bit set without the three-pin bit selects the two-pin rc oscillator.
// - rc bit together with the three-pin bit selects the three-pin rc mode.
// - the startup resistor is connected only in crystal or resonator mode.
// - portb1_osc_third is a plain input after reset unless three-pin rc.
// - a low on the reset pin puts the device in its startup reset state.
// - the device pulls its reset pin low on watchdog or illegal address reset.
// - the irq pin triggers on falling edge only or on edge and low level.
// - with the option set, keyboard_lines join the irq inverted, same mode.
// - all port A lines are inputs after reset, then under software control.
// - portb0_line is an input after reset.
// - with the pulldown option, software may enable port pulldowns.
// - with an rc oscillator the startup delay is 4064 or 16 op cycles.
module pocic_top #(
  parameter int LONG_DLY = pocic_pkg::LONG_DLY_CYC,
  parameter int SHORT_DLY = pocic_pkg::SHORT_DLY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire pocic_pkg::pocic_bus_t bus,
  output logic [7:0] rdata,
  // option straps
  input wire logic [7:0] option_straps,
  // reset pin and internal reset causes
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  input wire logic wdog_reset,
  input wire logic illegal_addr_reset,
  output logic core_reset,
  // clock and oscillator control
  output logic op_clk_en,
  output logic startup_res_en,
  output logic osc_third_en,
  // interrupt inputs and outputs
  input wire logic irq_pin_n,
  input wire logic [3:0] keyboard_lines,
  input wire logic irq_ack,
  output logic irq_req,
  output logic irq_out,
  // port direction and pulldowns
  output logic [7:0] pa_dir,
  output logic [1:0] pb_dir,
  output logic [7:0] pa_pd_en,
  output logic [1:0] pb_pd_en
);
  initial begin
    if (LONG_DLY < 1 || LONG_DLY >= 2 ** pocic_pkg::DLY_W ||
        SHORT_DLY < 1 || SHORT_DLY > LONG_DLY) begin
      $error("pocic_top: delay parameters out of range");
    end
  end
  localparam logic [pocic_pkg::DLY_W-1:0] LONG_M1 =
    pocic_pkg::DLY_W'(LONG_DLY - 1);
  localparam logic [pocic_pkg::DLY_W-1:0] SHORT_M1 =
    pocic_pkg::DLY_W'(SHORT_DLY - 1);
  logic [7:0] option, next_option;
  logic opt_caught, next_opt_caught;
  logic div, next_div, next_op_clk_en;
  pocic_pkg::pocic_osc_t osc_mode;
  pocic_pkg::pocic_pwr_t pstate, next_pstate;
  logic [pocic_pkg::DLY_W-1:0] dly_cnt, next_dly_cnt;
  logic next_core_reset, next_res_en, next_third_en, next_pin_oe;
  logic rst_pin_f, irq_pin_f;
  logic [3:0] kbd_f;
  logic req_lvl, req_prev, next_req_prev, edge_seen;
  logic irq_flag, next_irq_flag, next_irq_req, next_irq_out;
  logic [pocic_pkg::NUM_EVT-1:0] stat, next_stat, mask, next_mask, evt;
  logic [7:0] next_pa_dir, next_pa_pdi, pa_pdi, next_rdata, next_pa_pd;
  logic [1:0] next_pb_dir, pb_pdi, next_pb_pdi, next_pb_pd;
  logic wr_hit_stat;

  // pins from outside pass four flops: three stages and the filter
  pocic_sync #(.W(6), .IDLE(6'h30)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({reset_pin_n_in, irq_pin_n, keyboard_lines}),
    .dout({rst_pin_f, irq_pin_f, kbd_f})
  );

  // option straps are caught once, a cycle after reset release
  always_comb begin
    next_option = option;
    next_opt_caught = 1'b1;
    if (!opt_caught) begin
      next_option = option_straps;
    end
  end

  // oscillator mode from rc and three-pin bits
  always_comb begin
    if (!option[pocic_pkg::OPT_RC]) begin
      osc_mode = pocic_pkg::OSC_XTAL;
    end else if (option[pocic_pkg::OPT_THREE_PIN]) begin
      osc_mode = pocic_pkg::OSC_RC3;
    end else begin
      osc_mode = pocic_pkg::OSC_RC2;
    end
  end

  // divide by two; one enable pulse per two oscillator cycles
  always_comb begin
    next_div = ~div;
    next_op_clk_en = div;
    next_res_en = (osc_mode == pocic_pkg::OSC_XTAL);
    next_third_en = (osc_mode == pocic_pkg::OSC_RC3);
  end

  // reset sequencer; the pin pulldown also drives us back into reset
  always_comb begin
    next_pstate = pstate;
    next_dly_cnt = dly_cnt;
    next_pin_oe = wdog_reset | illegal_addr_reset;
    case (pstate)
      pocic_pkg::PS_RESET: begin
        if (rst_pin_f && opt_caught) begin
          next_pstate = pocic_pkg::PS_DELAY;
          // short delay only honoured with an rc oscillator
          if (option[pocic_pkg::OPT_SHORT_DLY] &&
              option[pocic_pkg::OPT_RC]) begin
            next_dly_cnt = SHORT_M1;
          end else begin
            next_dly_cnt = LONG_M1;
          end
        end
      end
      pocic_pkg::PS_DELAY: begin
        if (div) begin
          if (dly_cnt == '0) begin
            next_pstate = pocic_pkg::PS_RUN;
          end else begin
            next_dly_cnt = dly_cnt - 1'b1;
          end
        end
      end
      pocic_pkg::PS_RUN: next_pstate = pocic_pkg::PS_RUN;
      default: next_pstate = pocic_pkg::PS_RESET;
    endcase
    if (!rst_pin_f || next_pin_oe) begin
      next_pstate = pocic_pkg::PS_RESET;
    end
    next_core_reset = (next_pstate != pocic_pkg::PS_RUN);
  end

  // combined request: irq pin low, or any enabled keyboard line high
  always_comb begin
    req_lvl = ~irq_pin_f;
    if (option[pocic_pkg::OPT_KBD_IRQ]) begin
      req_lvl = req_lvl | (|kbd_f);
    end
    next_req_prev = req_lvl;
    edge_seen = req_lvl & ~req_prev;
    next_irq_flag = irq_flag;
    if (irq_ack) begin
      next_irq_flag = 1'b0;
    end
    if (edge_seen) begin
      next_irq_flag = 1'b1;
    end
    // level mode keeps asking while the line stays active
    next_irq_req = next_irq_flag |
      (option[pocic_pkg::OPT_LEVEL_IRQ] & req_lvl);
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    evt = '0;
    evt[pocic_pkg::ST_IRQ_EDGE] = edge_seen;
    evt[pocic_pkg::ST_WDOG] = wdog_reset;
    evt[pocic_pkg::ST_ILLEGAL] = illegal_addr_reset;
    wr_hit_stat = bus.wr && bus.addr == pocic_pkg::OFS_IRQ_STAT;
    next_stat = stat;
    if (wr_hit_stat) begin
      next_stat = stat & ~bus.wdata[pocic_pkg::NUM_EVT-1:0];
    end
    next_stat = next_stat | evt;
    next_mask = mask;
    if (bus.wr && bus.addr == pocic_pkg::OFS_IRQ_MASK) begin
      next_mask = bus.wdata[pocic_pkg::NUM_EVT-1:0];
    end
    next_irq_out = |(next_stat & next_mask);
  end

  // port direction and pulldown inhibit registers
  always_comb begin
    next_pa_dir = pa_dir;
    next_pb_dir = pb_dir;
    next_pa_pdi = pa_pdi;
    next_pb_pdi = pb_pdi;
    if (bus.wr) begin
      case (bus.addr)
        pocic_pkg::OFS_PA_DIR: next_pa_dir = bus.wdata;
        pocic_pkg::OFS_PB_DIR: next_pb_dir = bus.wdata[1:0];
        pocic_pkg::OFS_PA_PDI: next_pa_pdi = bus.wdata;
        pocic_pkg::OFS_PB_PDI: next_pb_pdi = bus.wdata[1:0];
        default: next_pa_dir = pa_dir;
      endcase
    end
    if (core_reset) begin // any reset returns the ports to inputs
      next_pa_dir = pocic_pkg::RST_BYTE;
      next_pb_dir = 2'h0;
    end
    // the third oscillator pin is never a port output in three-pin mode
    if (osc_mode == pocic_pkg::OSC_RC3) begin
      next_pb_dir[1] = 1'b0;
    end
    next_pa_pd = {8{option[pocic_pkg::OPT_PULLDOWN]}} & ~next_pa_pdi;
    next_pb_pd = {2{option[pocic_pkg::OPT_PULLDOWN]}} & ~next_pb_pdi;
    if (osc_mode == pocic_pkg::OSC_RC3) begin
      next_pb_pd[1] = 1'b0;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = pocic_pkg::RST_BYTE;
    if (bus.rd) begin
      case (bus.addr)
        pocic_pkg::OFS_PA_DIR: next_rdata = pa_dir;
        pocic_pkg::OFS_PB_DIR: next_rdata = {6'h00, pb_dir};
        pocic_pkg::OFS_IRQ_STAT: next_rdata = {5'h00, stat};
        pocic_pkg::OFS_IRQ_MASK: next_rdata = {5'h00, mask};
        pocic_pkg::OFS_STATE: next_rdata = {5'h00, irq_req, pstate};
        pocic_pkg::OFS_PA_PDI: next_rdata = pa_pdi;
        pocic_pkg::OFS_PB_PDI: next_rdata = {6'h00, pb_pdi};
        pocic_pkg::OFS_OPTION: next_rdata = option;
        default: next_rdata = pocic_pkg::RST_BYTE;
      endcase
    end
  end

  // all state but reset_pin_n_out registered here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      option <= pocic_pkg::RST_BYTE;
      opt_caught <= 1'b0;
      div <= 1'b0;
      op_clk_en <= 1'b0;
      startup_res_en <= 1'b1;
      osc_third_en <= 1'b0;
      pstate <= pocic_pkg::PS_RESET;
      dly_cnt <= '0;
      core_reset <= 1'b1;
      reset_pin_n_oe <= 1'b0;
      req_prev <= 1'b0;
      irq_flag <= 1'b0;
      irq_req <= 1'b0;
      stat <= pocic_pkg::RST_EVT;
      mask <= pocic_pkg::RST_EVT;
      irq_out <= 1'b0;
      pa_dir <= pocic_pkg::RST_BYTE;
      pb_dir <= 2'h0;
      pa_pdi <= pocic_pkg::RST_BYTE;
      pb_pdi <= 2'h0;
      pa_pd_en <= pocic_pkg::RST_BYTE;
      pb_pd_en <= 2'h0;
      rdata <= pocic_pkg::RST_BYTE;
    end else begin
      option <= next_option;
      opt_caught <= next_opt_caught;
      div <= next_div;
      op_clk_en <= next_op_clk_en;
      startup_res_en <= next_res_en;
      osc_third_en <= next_third_en;
      pstate <= next_pstate;
      dly_cnt <= next_dly_cnt;
      core_reset <= next_core_reset;
      reset_pin_n_oe <= next_pin_oe;
      req_prev <= next_req_prev;
      irq_flag <= next_irq_flag;
      irq_req <= next_irq_req;
      stat <= next_stat;
      mask <= next_mask;
      irq_out <= next_irq_out;
      pa_dir <= next_pa_dir;
      pb_dir <= next_pb_dir;
      pa_pdi <= next_pa_pdi;
      pb_pdi <= next_pb_pdi;
      pa_pd_en <= next_pa_pd;
      pb_pd_en <= next_pb_pd;
      rdata <= next_rdata;
    end
  end
  // the pulldown only ever drives low
  always_ff @(posedge clk) begin
    reset_pin_n_out <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_div;
    op_clk_en |=> !op_clk_en ##1 op_clk_en;
  endproperty
  a_div: assert property (p_div) else $error("op clock not half rate");
  property p_rc2;
    osc_mode == pocic_pkg::OSC_RC2 |=> !startup_res_en && !osc_third_en;
  endproperty
  a_rc2: assert property (p_rc2) else $error("two-pin rc misdecoded");
  property p_rc3;
    osc_mode == pocic_pkg::OSC_RC3 |=> osc_third_en && pb_dir[1] == 1'b0;
  endproperty
  a_rc3: assert property (p_rc3) else $error("three-pin rc misdecoded");
  property p_xtal;
    osc_mode == pocic_pkg::OSC_XTAL |=> startup_res_en;
  endproperty
  a_xtal: assert property (p_xtal) else $error("startup resistor off");
  property p_pull;
    (wdog_reset || illegal_addr_reset) |=> reset_pin_n_oe ##1 core_reset;
  endproperty
  a_pull: assert property (p_pull) else $error("reset pin not pulled");
  property p_pin_rst;
    !rst_pin_f |=> core_reset && pstate == pocic_pkg::PS_RESET;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");
  property p_edge;
    (req_lvl && !req_prev) |=> irq_req && stat[pocic_pkg::ST_IRQ_EDGE];
  endproperty
  a_edge: assert property (p_edge) else $error("irq edge lost");
  property p_kbd;
    (option[pocic_pkg::OPT_KBD_IRQ] && |kbd_f) |-> req_lvl;
  endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard line not ored");
  // the divider phase at entry moves the end by one cycle; a reset may cut it
  property p_short;
    pstate == pocic_pkg::PS_DELAY && $past(pstate) == pocic_pkg::PS_RESET &&
      dly_cnt == SHORT_M1 && SHORT_DLY == 16
      |-> ((##[1:32] pstate == pocic_pkg::PS_RESET) or
      (##[31:32] pstate == pocic_pkg::PS_RUN));
  endproperty
  a_short: assert property (p_short) else $error("short delay wrong");
endmodule : pocic_top
`default_nettype wire

// ### bench/pocic_far_model.sv
// Purpose: far side of the pins: reset circuit and interrupt sources
// Assumes: reset pin has a pullup, device only pulls it low
// Notes: osc third pin is left open, so it has no connection here
`timescale 1ns/10ps
`default_nettype none
module pocic_far_model (
  // device side of the reset pin
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in,
  // bench commands
  input wire logic ext_low,
  input wire logic irq_low,
  input wire logic [3:0] keys,
  // pins into the device
  output logic irq_pin_n,
  output logic [3:0] kbd
);
  // wired level: pullup unless either party pulls low
  assign pin_in = !(ext_low || (pin_oe && !pin_out));
  // irq source and key switches; third pin never driven
  assign irq_pin_n = !irq_low;
  assign kbd = keys;
endmodule : pocic_far_model
`default_nettype wire

// ### bench/pin_option_clock_irq_config_bench.sv
// Purpose: self-checking bench for pocic_top
// Assumes: far model closes the reset and irq pins
// Notes: long delay shortened to keep the run brief
`timescale 1ns/10ps
`default_nettype none
module pin_option_clock_irq_config_bench;
  localparam int LDLY = 40;
  localparam int SDLY = 16;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  pocic_pkg::pocic_bus_t bus = '0;
  logic [7:0] opt = 8'h00;
  logic wdog = 1'b0;
  logic illeg = 1'b0;
  logic ack = 1'b0;
  logic ext_low = 1'b0;
  logic irq_low = 1'b0;
  logic [3:0] keys = 4'h0;
  logic pin_in, pin_out, pin_oe, core_rst, op_en, res_en, third_en;
  logic irq_req, irq_out, irq_pin_n, a;
  logic [7:0] rdata, pa_dir, pa_pd;
  logic [1:0] pb_dir, pb_pd;
  logic [3:0] kbd;
  logic [7:0] v;
  logic [7:0] modes [6] = '{8'h00, 8'h20, 8'h60, 8'hA0, 8'h80, 8'hE0};
  int err_count = 0;
  int compares = 0;
  int seed = 32'h396EF2A9;
  int n, d;

  // 20 MHz clock
  always #25 clk = ~clk;

  pocic_top #(.LONG_DLY(LDLY), .SHORT_DLY(SDLY)) dut (
    .clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .option_straps(opt), .reset_pin_n_in(pin_in),
    .reset_pin_n_out(pin_out), .reset_pin_n_oe(pin_oe),
    .wdog_reset(wdog), .illegal_addr_reset(illeg),
    .core_reset(core_rst), .op_clk_en(op_en),
    .startup_res_en(res_en), .osc_third_en(third_en),
    .irq_pin_n(irq_pin_n), .keyboard_lines(kbd), .irq_ack(ack),
    .irq_req(irq_req), .irq_out(irq_out), .pa_dir(pa_dir),
    .pb_dir(pb_dir), .pa_pd_en(pa_pd), .pb_pd_en(pb_pd)
  );

  pocic_far_model far (
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .ext_low(ext_low), .irq_low(irq_low), .keys(keys),
    .irq_pin_n(irq_pin_n), .kbd(kbd)
  );

  // verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic sig(input int k);
    return (k == 0) ? core_rst : irq_req;
  endfunction : sig

  // bounded wait, sampled at falling edges; n holds the edges spent
  task automatic wait_sig(input int k, input logic lv, input int lim);
    n = 0;
    @(negedge clk);
    while (sig(k) !== lv) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("[ERR] %0t wait %h exp %h", $time, sig(k), lv);
        stop_test();
      end
    end
    // back on the rising edge so the next drive is clean
    @(posedge clk);
  endtask : wait_sig

  // one-cycle strobes, idle edge after each so no double drive
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    bus <= '{ad, dt, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    bus <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask : rd

  task automatic ack_irq(input logic exp);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(negedge clk);
    chk(8'(irq_req), 8'(exp));
    @(posedge clk);
  endtask : ack_irq

  // reset with straps, then wait out the startup delay
  task automatic boot(input logic [7:0] o);
    opt <= o;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    wait_sig(0, 1'b0, 2 * LDLY + 40);
  endtask : boot

  initial begin
    // oscillator modes, delays and pin roles
    foreach (modes[i]) begin
      boot(modes[i]);
      d = (modes[i][5] && modes[i][7]) ? SDLY : LDLY;
      chk(8'(n >= 2 * d - 2 && n <= 2 * d + 12), 8'h01);
      chk(8'(res_en), 8'(!modes[i][5]));
      chk(8'(third_en), 8'(modes[i][5] & modes[i][6]));
      chk(pa_dir, 8'h00);
      chk(8'(pb_dir), 8'h00);
      wr(pocic_pkg::OFS_OPTION, 8'hFF);
      rd(pocic_pkg::OFS_OPTION, modes[i]);
      wr(pocic_pkg::OFS_PB_DIR, 8'h03);
      chk(8'(pb_dir), (modes[i][5] & modes[i][6]) ? 8'h01 : 8'h03);
      $display("mode %h done", modes[i]);
    end
    // operating clock alternates every cycle
    repeat (10) begin
      @(negedge clk);
      a = op_en;
      @(negedge clk);
      chk(8'(a ^ op_en), 8'h01);
    end
    @(posedge clk);
    $display("op clock done");
    // random directions and pulldown inhibits
    boot(8'h08);
    repeat (8) begin
      v = 8'($random(seed));
      wr(pocic_pkg::OFS_PA_DIR, v);
      chk(pa_dir, v);
      wr(pocic_pkg::OFS_PA_PDI, ~v);
      chk(pa_pd, v);
      wr(pocic_pkg::OFS_PB_PDI, v);
      chk(8'(pb_pd), {6'h00, ~v[1:0]});
    end
    rd(8'h1F, 8'h00);
    rd(pocic_pkg::OFS_STATE, 8'(pocic_pkg::PS_RUN));
    boot(8'h00);
    chk(pa_pd, 8'h00);
    $display("ports done");
    // edge mode irq, mask, sticky status, keys ignored
    wr(pocic_pkg::OFS_IRQ_MASK, 8'h07);
    rd(pocic_pkg::OFS_IRQ_MASK, 8'h07);
    irq_low <= 1'b1;
    wait_sig(1, 1'b1, 10);
    rd(pocic_pkg::OFS_IRQ_STAT, 8'h01);
    chk(8'(irq_out), 8'h01);
    ack_irq(1'b0);
    wr(pocic_pkg::OFS_IRQ_STAT, 8'h01);
    chk(8'(irq_out), 8'h00);
    irq_low <= 1'b0;
    keys <= 4'hF;
    repeat (10) @(posedge clk);
    chk(8'(irq_req), 8'h00);
    keys <= 4'h0;
    // level mode with keyboard lines joined in
    boot(8'h06);
    for (int i = 0; i < 4; i++) begin
      keys <= 4'(1 << i);
      wait_sig(1, 1'b1, 10);
      ack_irq(1'b1);
      keys <= 4'h0;
      repeat (8) @(posedge clk);
      ack_irq(1'b0);
    end
    $display("irq done");
    // watchdog and illegal address pull the reset pin
    for (int i = 0; i < 2; i++) begin
      wr(pocic_pkg::OFS_IRQ_STAT, 8'h07);
      wdog <= (i == 0);
      illeg <= (i == 1);
      @(posedge clk);
      wdog <= 1'b0;
      illeg <= 1'b0;
      @(negedge clk);
      chk({6'h00, pin_oe, pin_out}, 8'h02);
      wait_sig(0, 1'b1, 10);
      wait_sig(0, 1'b0, 2 * LDLY + 40);
      rd(pocic_pkg::OFS_IRQ_STAT, 8'(2 << i));
    end
    // external reset on the pin
    wr(pocic_pkg::OFS_PA_DIR, 8'hFF);
    ext_low <= 1'b1;
    wait_sig(0, 1'b1, 10);
    ext_low <= 1'b0;
    wait_sig(0, 1'b0, 2 * LDLY + 40);
    chk(pa_dir, 8'h00);
    $display("reset pin done");
    stop_test();
  end
endmodule : pin_option_clock_irq_config_bench
`default_nettype wire
